/* rtl/seq_consts.svh */
/*
  Constants of the external memory cycle sequencer: clock rates, derived unit
  length, register offsets, field positions and reset values.
  Assumes it is included by bare name from the unit divider and the sequencer.
*/
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// Clocking of the unit timer
`define MCLK_PERIOD_NS 5
`define REF_CLK_PERIOD_NS 200
`define PLL_MULTIPLIER 4
`define CYCLE_CLK_PERIOD_NS (`REF_CLK_PERIOD_NS / `PLL_MULTIPLIER)
`define HALF_UNIT_NS (`CYCLE_CLK_PERIOD_NS / 2)
`define UNIT_CYCLES (`HALF_UNIT_NS / `MCLK_PERIOD_NS)

// Register offsets
`define REG_PHASE_CFG 8'h00
`define REG_STROBE_CFG 8'h04
`define REG_STATUS 8'h08

// Field positions
`define EARLY_WRITE_BIT 20
`define WAIT_SYNC_BIT 32

// Reset values and limits
`define PHASE_CFG_RST 12'hfff
`define STROBE_CFG_RST 21'h028c3e
`define STROBE_MAX 5'h1f

`endif

/* rtl/seq_pkg.sv */
/*
  Types of the external memory cycle sequencer: phase states, the access
  request carrier and the state records of each module.
  Assumes seq_consts.svh is on the include path.
*/
package seq_pkg;

  typedef enum logic [8:0] {
    st_idle = 9'h001,
    phase_addr_setup = 9'h002,
    phase_addr_hold = 9'h004,
    phase_turnaround = 9'h008,
    phase_extendable_setup = 9'h010,
    phase_data_transfer = 9'h020,
    phase_data_hold = 9'h040,
    st_pad = 9'h080,
    st_internal = 9'h100
  } phase_e;

  typedef struct packed {
    logic internal;
    logic refresh;
    logic write;
    logic [3:0] byte_en;
    logic [29:0] word_addr;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    phase_e phase;
    logic [2:0] ucnt;
    logic par;
    logic [4:0] scnt;
    mem_req_s req;
    logic [11:0] lens;
    logic [4:0] s1;
    logic early;
    logic [11:0] phase_cfg;
    logic [20:0] strobe_cfg;
    logic [31:0] rdata;
    logic rd_valid;
    logic [31:0] rd_data;
    logic taken;
    logic [29:0] bus_o;
    logic bus_oe;
    logic d0_o;
    logic d1_o;
    logic rd_n;
    logic as_n;
    logic ls_n;
    logic [3:0] wr_n;
    logic clk_d;
    logic clk_o;
    logic [32:0] sync1;
    logic [32:0] sync2;
  } seq_state_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
    logic lvl;
  } div_state_s;

  typedef struct packed {
    logic strobe_n;
  } dstrobe_state_s;

endpackage

/* rtl/unit_divider.sv */
/*
  Half-cycle unit timer: a one-cycle enable at each unit boundary and the
  level of the derived processor clock.
  Assumes one clock at the rate given in seq_consts.svh.
*/
`timescale 1ns/1ps
`include "seq_consts.svh"

module unit_divider (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Unit timing
  output logic tick_out,
  output logic lvl_out
);

  seq_pkg::div_state_s r;
  seq_pkg::div_state_s n;

  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (r.cnt == 3'(`UNIT_CYCLES - 1)) begin
      n.cnt = 3'h0;
      n.tick = 1'b1;
      // Level flips every unit, so the unit is exactly half a period
      n.lvl = ~r.lvl; // RL1 RL2
    end else begin
      n.cnt = r.cnt + 3'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick_out = r.tick;
  assign lvl_out = r.lvl;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  unit_spacing_a: assert property (tick_out |=> !tick_out [*4] ##1 tick_out) // RL1
    else $error("unit enable spacing wrong");
  clock_period_a: assert property ($rose(lvl_out) |=> lvl_out [*4] ##1 !lvl_out [*5] ##1 lvl_out) // RL2
    else $error("derived clock period wrong");

endmodule

/* rtl/delayed_strobe.sv */
/*
  One delayed strobe: with a nonzero delay, falls that many units after the address
  strobe falls and rises when the data transfer phase ends; a zero delay holds it low for the whole cycle.
  Assumes its inputs come from the sequencer's registered phase state.
*/
`timescale 1ns/1ps

module delayed_strobe (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Phase information
  input wire logic in_cycle_in,
  input wire logic active_in,
  input wire logic [4:0] units_in,
  input wire logic [4:0] delay_in,
  // Strobe
  output logic strobe_n_out
);

  seq_pkg::dstrobe_state_s r;
  seq_pkg::dstrobe_state_s n;

  always_comb begin
    n = r;
    // A zero delay holds the strobe low for the whole cycle
    n.strobe_n = !((delay_in == 5'h00 && in_cycle_in) || (active_in && units_in >= delay_in)); // RL21
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      r <= '{strobe_n: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign strobe_n_out = r.strobe_n;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  dstrobe_high_a: assert property (delay_in != 5'h00 && !active_in |=> strobe_n_out) // RL21
    else $error("delayed strobe low outside its window");
  dstrobe_zero_a: assert property (delay_in == 5'h00 && in_cycle_in |=> !strobe_n_out) // RL21
    else $error("zero-delay strobe not low");

endmodule

/* rtl/ext_memory_cycle_sequencer.sv */
/*
  External memory cycle sequencer: six configurable phases counted in
  half-cycle units, multiplexed address/data pins, address, read, length,
  delayed and byte write strobes, and the internal access mirror.
  Assumes requests and register accesses come from logic on mclk_in; memory
  pins and the wait request arrive asynchronously and are synchronised here.
*/
// Added by the designer: strobed register access and the register offsets.
// Overview of operation
// RL1: Unit is half the derived clock period.
// RL2: Derived clock period is reference over multiplier.
// RL3: Strobe edges coincide with derived clock edges.
// RL4: Cycle runs six phases in fixed order.
// RL5: Each phase lasts one to four units.
// RL6: Reset makes every phase four units.
// RL7: Fourth phase stretches while wait requested.
// RL8: Odd totals get one padding unit.
// RL9: Internal access mirrors address, strobes stay inactive.
// RL10: Address driven only in first two phases.
// RL11: Byte writes select lanes by write strobes.
// RL12: Data bits 1, 0 use flag pins.
// RL13: Read data sampled at fifth phase end.
// RL14: Write data held through hold and padding.
// RL15: Write flag low for writes, then data 0.
// RL16: Refresh flag low for refresh, then data 1.
// RL17: Read strobe low in phases four, five.
// RL18: Read strobe grows with lengths and waits.
// RL19: Address strobe low phases two to five.
// RL20: Length strobe low configured units from fall.
// RL21: Delayed strobes fall late, rise at five's end.
// RL22: Cycle equals phases plus waits plus pad.
// RL23: Wait inserts whole units until withdrawn.
`timescale 1ns/1ps
`include "seq_consts.svh"

module ext_memory_cycle_sequencer (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Access requests and read answers
  input wire logic req_valid_in,
  input wire seq_pkg::mem_req_s req_in,
  output logic req_taken_out,
  output logic rd_valid_out,
  output logic [31:0] rd_data_out,
  // Derived clock
  output logic cycle_clock_output_out,
  // Multiplexed address and data pins
  input wire logic [29:0] muxed_addr_data_bus_in,
  output logic [29:0] muxed_addr_data_bus_out,
  output logic muxed_addr_data_bus_oe_out,
  input wire logic write_flag_data0_in,
  output logic write_flag_data0_out,
  output logic write_flag_data0_oe_out,
  input wire logic refresh_flag_data1_in,
  output logic refresh_flag_data1_out,
  output logic refresh_flag_data1_oe_out,
  // Strobes and wait
  output logic read_strobe_n_out,
  output logic address_strobe_n_out,
  output logic length_strobe_n_out,
  output logic [2:0] delayed_strobes_n_out,
  output logic [3:0] byte_write_strobes_n_out,
  input wire logic mem_wait_in
);

  seq_pkg::seq_state_s r;
  seq_pkg::seq_state_s n;
  logic tick;
  logic lvl;
  logic [1:0] cur_len;
  logic last;
  logic wait_s;
  logic in_p12;
  logic in_p25;
  logic in_p26;
  logic in_data;
  logic in_ext;

  ////////////////////////////////////////////////////////////////////////////
  // Unit timer and delayed strobes

  unit_divider u_div (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .tick_out(tick),
    .lvl_out(lvl)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_dly
      delayed_strobe u_dly (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .in_cycle_in(in_ext),
        .active_in(in_p25),
        .units_in(r.scnt),
        .delay_in(r.strobe_cfg[5*gi+5 +: 5]),
        .strobe_n_out(delayed_strobes_n_out[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Phase decode

  always_comb begin
    unique case (r.phase)
      seq_pkg::st_idle: cur_len = 2'h0;
      seq_pkg::phase_addr_setup: cur_len = r.lens[1:0];
      seq_pkg::phase_addr_hold: cur_len = r.lens[3:2];
      seq_pkg::phase_turnaround: cur_len = r.lens[5:4];
      seq_pkg::phase_extendable_setup: cur_len = r.lens[7:6];
      seq_pkg::phase_data_transfer: cur_len = r.lens[9:8];
      seq_pkg::phase_data_hold: cur_len = r.lens[11:10];
      seq_pkg::st_pad: cur_len = 2'h0;
      seq_pkg::st_internal: cur_len = 2'h1;
    endcase
  end

  // Length codes are units minus one, so a phase spans one to four units
  assign last = (r.ucnt == {1'b0, cur_len}); // RL5
  assign wait_s = r.sync2[`WAIT_SYNC_BIT];
  assign in_p12 = r.phase inside {seq_pkg::phase_addr_setup, seq_pkg::phase_addr_hold};
  assign in_p25 = r.phase inside {seq_pkg::phase_addr_hold, seq_pkg::phase_turnaround,
                                  seq_pkg::phase_extendable_setup, seq_pkg::phase_data_transfer};
  assign in_p26 = in_p25 || r.phase == seq_pkg::phase_data_hold;
  assign in_data = in_p26 && !in_p12 || r.phase == seq_pkg::st_pad;
  assign in_ext = in_p12 || in_data;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    n.taken = 1'b0;
    n.rd_valid = 1'b0;
    n.sync1 = {mem_wait_in, muxed_addr_data_bus_in, refresh_flag_data1_in, write_flag_data0_in};
    n.sync2 = r.sync1;
    n.clk_d = lvl;
    n.clk_o = r.clk_d; // RL3

    // Register writes change the next cycle's settings, except the delayed strobe delays, which act at once
    if (reg_wr_in) begin
      case (reg_addr_in)
        `REG_PHASE_CFG: n.phase_cfg = reg_wdata_in[11:0];
        `REG_STROBE_CFG: n.strobe_cfg = reg_wdata_in[20:0];
        default: ;
      endcase
    end
    n.rdata = 32'h0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `REG_PHASE_CFG: n.rdata = {20'h0, r.phase_cfg};
        `REG_STROBE_CFG: n.rdata = {11'h0, r.strobe_cfg};
        `REG_STATUS: n.rdata = {22'h0, wait_s, r.phase};
        default: n.rdata = 32'h0;
      endcase
    end

    if (tick) begin
      n.par = ~r.par;
      n.ucnt = last ? 3'h0 : r.ucnt + 3'h1;
      if (in_p26 && r.scnt != `STROBE_MAX) begin
        n.scnt = r.scnt + 5'h01;
      end
      unique case (r.phase)
        seq_pkg::st_idle: begin
        end
        seq_pkg::phase_addr_setup: begin
          if (last) begin
            n.phase = seq_pkg::phase_addr_hold; // RL4
            n.scnt = 5'h00;
          end
        end
        seq_pkg::phase_addr_hold: begin
          if (last) begin
            n.phase = seq_pkg::phase_turnaround; // RL4
          end
        end
        seq_pkg::phase_turnaround: begin
          if (last) begin
            n.phase = seq_pkg::phase_extendable_setup; // RL4
          end
        end
        seq_pkg::phase_extendable_setup: begin
          if (last && wait_s) begin
            // Each wait unit repeats the last unit of the phase
            n.ucnt = r.ucnt; // RL7 RL23 RL18
          end else if (last) begin
            n.phase = seq_pkg::phase_data_transfer; // RL4
          end
        end
        seq_pkg::phase_data_transfer: begin
          if (last) begin
            n.phase = seq_pkg::phase_data_hold; // RL4
            if (!r.req.write && !r.req.refresh) begin
              // Full word captured; byte selection is the requester's job
              n.rd_data = r.sync2[31:0]; // RL13 RL11 RL12 RL17
              n.rd_valid = 1'b1;
            end
          end
        end
        seq_pkg::phase_data_hold: begin
          if (last) begin
            // Parity holds units so far minus one: clear means an odd total
            n.phase = r.par ? seq_pkg::st_idle : seq_pkg::st_pad; // RL8 RL22
          end
        end
        seq_pkg::st_pad: begin
          n.phase = seq_pkg::st_idle; // RL8
        end
        seq_pkg::st_internal: begin
          if (last) begin
            n.phase = seq_pkg::st_idle;
          end
        end
      endcase

      // Start only where the coming unit begins on a rising clock edge
      if (n.phase == seq_pkg::st_idle && lvl && req_valid_in) begin // RL8
        n.phase = req_in.internal ? seq_pkg::st_internal : seq_pkg::phase_addr_setup;
        n.req = req_in;
        n.lens = r.phase_cfg;
        n.s1 = r.strobe_cfg[4:0];
        n.early = r.strobe_cfg[`EARLY_WRITE_BIT];
        n.ucnt = 3'h0;
        n.par = 1'b0;
        n.scnt = 5'h00;
        n.taken = 1'b1;
      end
    end

    // Pins follow the registered phase one cycle later, as does the clock
    if (in_p12 || r.phase == seq_pkg::st_internal) begin
      n.bus_o = r.req.word_addr; // RL10 RL9
      n.bus_oe = 1'b1;
      n.d0_o = ~r.req.write; // RL15 RL9
      n.d1_o = (r.phase == seq_pkg::st_internal) | ~r.req.refresh; // RL16 RL9
    end else if (in_data && r.req.write) begin
      n.bus_o = r.req.wdata[31:2]; // RL14 RL12
      n.bus_oe = 1'b1;
      n.d0_o = r.req.wdata[0]; // RL15
      n.d1_o = r.req.wdata[1]; // RL16
    end else begin
      n.bus_o = r.bus_o;
      n.bus_oe = 1'b0; // RL13
      n.d0_o = 1'b1;
      n.d1_o = 1'b1;
    end
    n.as_n = !in_p25; // RL19
    n.rd_n = !(r.phase inside {seq_pkg::phase_extendable_setup, seq_pkg::phase_data_transfer}
               && !r.req.write && !r.req.refresh); // RL17 RL18
    n.ls_n = !(in_p26 && r.scnt < r.s1); // RL20
    for (int i = 0; i < 4; i++) begin
      n.wr_n[i] = !(r.req.write && r.req.byte_en[i] &&
                   (r.phase inside {seq_pkg::phase_extendable_setup, seq_pkg::phase_data_transfer}
                    || (r.phase == seq_pkg::phase_turnaround && r.early))); // RL11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      r <= '0;
      r.phase <= seq_pkg::st_idle;
      r.phase_cfg <= `PHASE_CFG_RST; // RL6
      r.lens <= `PHASE_CFG_RST; // RL6
      r.strobe_cfg <= `STROBE_CFG_RST;
      r.d0_o <= 1'b1;
      r.d1_o <= 1'b1;
      r.rd_n <= 1'b1;
      r.as_n <= 1'b1;
      r.ls_n <= 1'b1;
      r.wr_n <= 4'hf;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata_out = r.rdata;
  assign req_taken_out = r.taken;
  assign rd_valid_out = r.rd_valid;
  assign rd_data_out = r.rd_data;
  assign cycle_clock_output_out = r.clk_o;
  assign muxed_addr_data_bus_out = r.bus_o;
  assign muxed_addr_data_bus_oe_out = r.bus_oe;
  assign write_flag_data0_out = r.d0_o;
  assign write_flag_data0_oe_out = r.bus_oe;
  assign refresh_flag_data1_out = r.d1_o;
  assign refresh_flag_data1_oe_out = r.bus_oe;
  assign read_strobe_n_out = r.rd_n;
  assign address_strobe_n_out = r.as_n;
  assign length_strobe_n_out = r.ls_n;
  assign byte_write_strobes_n_out = r.wr_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  sequence seq_p4_last_wait;
    r.phase == seq_pkg::phase_extendable_setup && tick && last && wait_s;
  endsequence

  sequence seq_p6_odd_end;
    r.phase == seq_pkg::phase_data_hold && tick && last && !r.par;
  endsequence

  reset_lengths_a: assert property ($past(!rst_b_in) |-> r.phase_cfg == `PHASE_CFG_RST) // RL6
    else $error("phase lengths not at maximum after reset");
  phase_order_a: assert property ($changed(r.phase) && r.phase == seq_pkg::phase_data_transfer
                                  |-> $past(r.phase) == seq_pkg::phase_extendable_setup) // RL4
    else $error("data transfer not entered from extendable setup");
  phase_len_a: assert property (r.phase != seq_pkg::st_idle |-> r.ucnt <= 3'h3) // RL5
    else $error("phase unit count above four");
  wait_hold_a: assert property (seq_p4_last_wait |=> r.phase == seq_pkg::phase_extendable_setup) // RL7
    else $error("wait request did not hold the phase");
  wait_release_a: assert property (r.phase == seq_pkg::phase_extendable_setup && tick && last && !wait_s
                                   |=> r.phase == seq_pkg::phase_data_transfer) // RL23
    else $error("phase did not advance after wait withdrawn");
  pad_unit_a: assert property (seq_p6_odd_end |=> r.phase == seq_pkg::st_pad) // RL8
    else $error("odd cycle not padded");
  strobe_edge_a: assert property ($changed(address_strobe_n_out) |-> $past(tick, 2)) // RL3
    else $error("strobe edge off the unit grid");
  addr_strobe_a: assert property (!address_strobe_n_out |-> $past(in_p25)) // RL19
    else $error("address strobe low outside phases two to five");
  read_capture_a: assert property (rd_valid_out |-> !read_strobe_n_out
                                   && $past(r.phase) == seq_pkg::phase_data_transfer) // RL17
    else $error("read capture not at end of strobe");
  write_hold_a: assert property (r.phase == seq_pkg::st_pad && r.req.write |=> muxed_addr_data_bus_oe_out) // RL14
    else $error("write data dropped during padding");
  flag_write_a: assert property ($past(in_p12) |-> write_flag_data0_out == !$past(r.req.write)) // RL15
    else $error("write flag wrong in address phases");
  internal_quiet_a: assert property ($past(r.phase == seq_pkg::st_internal)
                                     |-> refresh_flag_data1_out && address_strobe_n_out
                                         && read_strobe_n_out && byte_write_strobes_n_out == 4'hf) // RL9
    else $error("strobe active during internal access");
  byte_lane_a: assert property (!byte_write_strobes_n_out[0] |-> $past(r.req.byte_en[0] && r.req.write)) // RL11
    else $error("byte strobe without enable");

endmodule

/* verif/mem_partner.sv */
/*
  Behavioural static memory facing the sequencer's pins, with an optional wait request.
  Assumes the bench resolves each shared pin from the sequencer's enables.
*/
`timescale 1ns/1ps

module mem_partner (
  // Clock and mode
  input wire logic mclk_in,
  input wire logic slow_in,
  // Pins from the sequencer
  input wire logic [31:0] word_in,
  input wire logic rd_n_in,
  input wire logic as_n_in,
  input wire logic [3:0] wr_n_in,
  // Pins toward the sequencer
  output logic [31:0] word_out,
  output logic wait_out
);
  logic [31:0] mem [0:255];
  logic [7:0] addr = 8'h00;
  logic as_q = 1'b1;
  logic [3:0] wr_q = 4'hf;
  logic [2:0] hold = 3'h0;
  logic [5:0] wcnt = 6'h00;

  initial begin
    word_out = 32'h0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 32'h3c5a0000 ^ (i * 32'h01010101);
    end
  end

  assign wait_out = (wcnt != 6'h00);

  always @(posedge mclk_in) begin
    as_q <= as_n_in;
    wr_q <= wr_n_in;
    if (as_q && !as_n_in) begin
      addr <= word_in[9:2];
      wcnt <= slow_in ? 6'h28 : 6'h00;
    end else if (wcnt != 6'h00) begin
      wcnt <= wcnt - 6'h01;
    end
    for (int b = 0; b < 4; b++) begin
      if (!wr_q[b] && wr_n_in[b]) begin
        mem[addr][8*b +: 8] <= word_in[8*b +: 8];
      end
    end
    hold <= !rd_n_in ? 3'h3 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
    // Released lines toggle each cycle, so a late sample matches the stored word only every second cycle
    word_out <= (hold != 3'h0 || !rd_n_in) ? mem[addr] : ~word_out;
  end
endmodule

/* verif/tb_ext_memory_cycle_sequencer.sv */
/*
  Self-checking bench of the external memory cycle sequencer.
  Assumes the sequencer, its package and the memory partner are compiled first.
*/
`timescale 1ns/1ps

module tb_ext_memory_cycle_sequencer;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic req_valid = 1'b0;
  seq_pkg::mem_req_s req = '0;
  logic slow = 1'b0;
  logic skip = 1'b0;
  logic [31:0] reg_rdata, rd_data, m_word, word;
  logic taken, rd_valid, clk_out, clk_q, oe, d0, d0_oe, d1, d1_oe, rd_n, as_n, as_q, ls_n, wt;
  logic [29:0] bus_o;
  logic [2:0] ds_n;
  logic [3:0] wr_n;
  logic [7:0] act, act_q;
  int miscompares = 0;
  int checks = 0;
  int cnt [8];
  int last [8];
  int run = 0;
  int runs = 0;
  // Active-time queues: 0 addr, 1 read, 2 length, 3..5 delayed, 6 bus enable, 7 byte 0 write
  int lq [8][$];
  logic [31:0] dq [$];
  logic [31:0] eq [$];
  logic [31:0] mirror [0:255];
  logic [31:0] seed = 32'd41;
  logic [11:0] pc = 12'hfff;
  logic [20:0] sc = 21'h028c3e;

  assign word = {oe ? bus_o : m_word[31:2], d1_oe ? d1 : m_word[1], d0_oe ? d0 : m_word[0]};
  assign act = {~wr_n[0], oe, ~ds_n, ~ls_n, ~rd_n, ~as_n};

  ext_memory_cycle_sequencer DUT (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .req_valid_in(req_valid),
    .req_in(req), .req_taken_out(taken), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
    .cycle_clock_output_out(clk_out), .muxed_addr_data_bus_in(word[31:2]),
    .muxed_addr_data_bus_out(bus_o), .muxed_addr_data_bus_oe_out(oe),
    .write_flag_data0_in(word[0]), .write_flag_data0_out(d0), .write_flag_data0_oe_out(d0_oe),
    .refresh_flag_data1_in(word[1]), .refresh_flag_data1_out(d1), .refresh_flag_data1_oe_out(d1_oe),
    .read_strobe_n_out(rd_n), .address_strobe_n_out(as_n), .length_strobe_n_out(ls_n),
    .delayed_strobes_n_out(ds_n), .byte_write_strobes_n_out(wr_n), .mem_wait_in(wt)
  );

  mem_partner MEM (
    .mclk_in(mclk_in), .slow_in(slow), .word_in(word), .rd_n_in(rd_n), .as_n_in(as_n),
    .wr_n_in(wr_n), .word_out(m_word), .wait_out(wt)
  );

  initial begin
    for (int i = 0; i < 256; i++) begin
      mirror[i] = 32'h3c5a0000 ^ (i * 32'h01010101);
    end
    for (int i = 0; i < 8; i++) begin
      cnt[i] = 0;
      last[i] = 0;
    end
    forever #2.5 mclk_in = ~mclk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_r(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Notes every expected pin effect of one access, then runs it to completion
  task automatic acc(input seq_pkg::mem_req_s r);
    int l [6];
    int s, t, i, dl;
    logic [31:0] d;
    for (i = 0; i < 6; i++) begin
      l[i] = pc[2*i +: 2] + 1;
    end
    s = l[1] + l[2] + l[3] + l[4];
    t = l[0] + s + l[5];
    if (r.internal) begin
      eq.push_back({r.word_addr, 1'b1, !r.write});
      lq[6].push_back(10);
    end else begin
      eq.push_back({r.word_addr, !r.refresh, !r.write});
      lq[0].push_back(s * 5);
      if (sc[4:0] != 5'h00) lq[2].push_back((sc[4:0] < s + l[5] ? sc[4:0] : s + l[5]) * 5);
      for (i = 0; i < 3; i++) begin
        dl = sc[5 + 5*i +: 5];
        if (dl == 0) lq[3 + i].push_back((t + t % 2) * 5);
        else if (dl < s) lq[3 + i].push_back((s - dl) * 5);
      end
      lq[6].push_back((r.write ? t + t % 2 : l[0] + l[1]) * 5);
      if (r.write && r.byte_en[0]) lq[7].push_back((l[3] + l[4] + (sc[20] ? l[2] : 0)) * 5);
      if (!r.write && !r.refresh) begin
        lq[1].push_back((l[3] + l[4]) * 5);
        dq.push_back(mirror[r.word_addr[7:0]]);
      end
      for (i = 0; i < 4; i++) begin
        if (r.write && r.byte_en[i]) mirror[r.word_addr[7:0]][8*i +: 8] = r.wdata[8*i +: 8];
      end
    end
    @(posedge mclk_in);
    req <= r;
    req_valid <= 1'b1;
    for (i = 0; i < 400 && taken !== 1'b1; i++) @(negedge mclk_in);
    @(posedge mclk_in);
    req_valid <= 1'b0;
    if (i == 400) miscompares++;
    for (i = 0; i < 100; i++) begin
      reg_r(8'h08, d);
      if (d[0] === 1'b1) break;
    end
    if (i == 100) miscompares++;
    repeat (12) @(posedge mclk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk_in) begin
    if (rst_b_in) begin
      for (int i = 0; i < 8; i++) begin
        if (act[i]) begin
          cnt[i]++;
        end else if (cnt[i] != 0) begin
          last[i] = cnt[i];
          if (!skip) chk(cnt[i], lq[i].size() ? lq[i].pop_front() : -1);
          cnt[i] = 0;
        end
      end
      if (act[6] && !act_q[6]) chk(word, eq.size() ? eq.pop_front() : 32'hx);
      if (rd_valid === 1'b1) chk(rd_data, dq.size() ? dq.pop_front() : 32'hx);
      if (as_n !== as_q) chk(clk_out ^ clk_q, 1);
      if (clk_out !== clk_q) begin
        if (runs > 1) chk(run, 5);
        runs++;
        run = 1;
      end else begin
        run++;
      end
    end
    act_q = act;
    as_q = as_n;
    clk_q = clk_out;
  end

  initial begin
    #300000;
    miscompares++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    seq_pkg::mem_req_s r;
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    reg_r(8'h00, d);
    chk(d, 32'h00000fff);
    reg_r(8'h04, d);
    chk(d, 32'h00028c3e);
    reg_w(8'h08, 32'hffffffff);
    reg_r(8'h08, d);
    chk(d, 32'h00000001);
    reg_r(8'h0c, d);
    chk(d, 32'h00000000);
    r = '0;
    r.word_addr = 30'h00000012;
    acc(r);
    for (int n = 0; n < 12; n++) begin
      d = xs();
      pc = (n == 0) ? 12'h000 : d[11:0];
      sc = {d[12], 15'h0000, d[17:13]};
      for (int k = 0; k < 3; k++) begin
        sc[5 + 5*k +: 5] = 5'(xs() % 31 + 1);
      end
      // Zero settings: length strobe never low, first delayed strobe low all cycle
      if (n == 0) sc[9:0] = 10'h000;
      reg_w(8'h00, {20'h0, pc});
      reg_w(8'h04, {11'h0, sc});
      reg_r(8'h00, d);
      chk(d, {20'h0, pc});
      d = xs();
      r = '0;
      r.write = 1'b1;
      r.word_addr = d[31:2];
      r.byte_en = d[3:0];
      r.wdata = xs();
      acc(r);
      r.write = 1'b0;
      acc(r);
      r.refresh = 1'b1;
      acc(r);
      r.refresh = 1'b0;
      r.internal = 1'b1;
      r.write = d[1];
      acc(r);
    end
    // Every noted result must have appeared by now
    d = eq.size() + dq.size();
    for (int i = 0; i < 8; i++) begin
      d += lq[i].size();
    end
    chk(d, 32'h00000000);
    // Short phases keep the memory's wait request alive at the end of phase four
    pc = 12'h000;
    reg_w(8'h00, 32'h0);
    slow <= 1'b1;
    skip = 1'b1;
    r = '0;
    r.word_addr = 30'h00000033;
    acc(r);
    for (int i = 0; i < 8; i++) begin
      lq[i].delete();
    end
    chk(last[1] > 10, 1);
    chk(last[0] > 20, 1);
    chk(eq.size() + dq.size(), 0);
    final_report();
  end
endmodule
